// ===== design/decoder_pkg.sv
`default_nettype none
package decoder_pkg;
   localparam int INSN_WIDTH = 14;
   localparam int DATA_WIDTH = 8;
   localparam int ADDR_WIDTH = 7;
   // Field positions
   localparam int DEST_BIT = 7;
   localparam int BITIDX_LSB = 7;
   // Prefixes (bits 13:12)
   localparam logic [1:0] PFX_BYTE = 2'h0;
   localparam logic [1:0] PFX_BIT = 2'h1;
   localparam logic [1:0] PFX_JUMP = 2'h2;
   localparam logic [1:0] PFX_LIT = 2'h3;
   // Byte-oriented nibbles (bits 11:8)
   localparam logic [3:0] NIB_MISC = 4'h0;
   localparam logic [3:0] NIB_CLR = 4'h1;
   localparam logic [3:0] NIB_SUB = 4'h2;
   localparam logic [3:0] NIB_DEC = 4'h3;
   localparam logic [3:0] NIB_OR = 4'h4;
   localparam logic [3:0] NIB_AND = 4'h5;
   localparam logic [3:0] NIB_XOR = 4'h6;
   localparam logic [3:0] NIB_ADD = 4'h7;
   localparam logic [3:0] NIB_MOV = 4'h8;
   localparam logic [3:0] NIB_COM = 4'h9;
   localparam logic [3:0] NIB_INC = 4'hA;
   localparam logic [3:0] NIB_DECSKP = 4'hB;
   localparam logic [3:0] NIB_RRC = 4'hC;
   localparam logic [3:0] NIB_RLC = 4'hD;
   localparam logic [3:0] NIB_SWAP = 4'hE;
   localparam logic [3:0] NIB_INCSKP = 4'hF;
   // Bit operation codes (bits 11:10)
   localparam logic [1:0] BOP_CLR = 2'h0;
   localparam logic [1:0] BOP_SET = 2'h1;
   localparam logic [1:0] BOP_TSC = 2'h2;
   localparam logic [1:0] BOP_TSS = 2'h3;
   // Literal nibbles
   localparam logic [3:0] LIT_OR = 4'h8;
   localparam logic [3:0] LIT_AND = 4'h9;
   localparam logic [3:0] LIT_XOR = 4'hA;
   localparam logic [1:0] LIT_MOV2 = 2'h0;
   localparam logic [1:0] LIT_RET2 = 2'h1;
   localparam logic [2:0] LIT_SUB3 = 3'h6;
   localparam logic [2:0] LIT_ADD3 = 3'h7;
   // Full control words
   localparam logic [13:0] W_STANDBY = 14'h0063;
   localparam logic [13:0] W_WDCLR = 14'h0064;
   localparam logic [13:0] W_RETURN = 14'h0008;
   localparam logic [13:0] W_RETINT = 14'h0009;
   // File addresses
   localparam logic [6:0] ADDR_TIMER_ZERO = 7'h01;
   localparam logic [6:0] ADDR_STATUS = 7'h03;
   localparam logic [6:0] ADDR_PORT_A = 7'h05;
   localparam logic [6:0] ADDR_PORT_B = 7'h06;
   // Status bit positions
   localparam int ST_C = 0;
   localparam int ST_DIGIT_CARRY = 1;
   localparam int ST_Z = 2;
   localparam logic [7:0] STATUS_RESET = 8'h18;

   typedef enum logic [3:0]
   {
      ALU_NONE, ALU_PASS_F, ALU_PASS_K, ALU_OR, ALU_AND, ALU_XOR,
      ALU_ADD, ALU_SUB, ALU_INC, ALU_DEC, ALU_COM, ALU_RLC, ALU_RRC,
      ALU_SWAP, ALU_ZERO, ALU_BIT
   } alu_op_type;

   typedef struct packed
   {
      alu_op_type alu_op;
      logic [7:0] literal;
      logic [6:0] file_addr;
      logic [2:0] bit_index;
      logic bit_value;
      logic use_literal;
      logic reads_file;
      logic write_acc;
      logic write_file;
      logic upd_z;
      logic upd_digit_carry;
      logic upd_c;
      logic upd_timeout_powerdown;
      logic skip_on_zero;
      logic bit_test;
      logic skip_if_set;
      logic pc_change;
      logic is_standby;
      logic is_wd_clear;
      logic is_return;
      logic clr_prescaler;
      logic pins_operand;
      logic status_flag_mask;
      logic illegal;
   } decode_type;
endpackage
`default_nettype wire

// ===== design/instruction_word_decoder.sv
// Functional notes
// - File OR/XOR/AND (nibbles 0100/0110/0101) update the zero flag only.
// - Decrement/increment-skip write the result, skip on zero, keep flags.
// - Rotates go through carry and change only the carry flag.
// - Bit ops are 01, two op bits, three bit-index bits, seven address bits.
// - Bit tests take one cycle, two on skip, and change no flags.
// - Literal XOR/OR/AND (1010/1000/1001) write the accumulator, set zero.
// - Literal subtract 110x and add 111x update carry, digit carry, zero.
// - Return-with-literal loads the accumulator, returns, takes two cycles.
// - Standby, watchdog-clear: one cycle, only timeout/power-down flags.
// - A PC change or true test takes two cycles, the second a no-op.
// - A file op on timer zero (dest 1 if present) clears the prescaler when prescaler_on_timer is set.
// - A port modified from itself is read from the pins, not the latch.
// - With status as destination, zero/carry flag writes are suppressed.
`default_nettype none
module instruction_word_decoder
(
   input wire logic clk,
   input wire logic rst,
   input wire logic insn_valid,
   input wire logic [13:0] insn_word,
   input wire logic test_result_zero,
   input wire logic prescaler_on_timer,
   output decoder_pkg::decode_type decode_out,
   output logic decode_valid,
   output logic flush_cycle,
   output logic busy
);
   //==========================================================
   // Decode
   //==========================================================
   decoder_pkg::decode_type dec_next;
   decoder_pkg::decode_type decode_reg;
   logic [1:0] pfx;
   logic [3:0] nib;
   logic dst;
   logic [6:0] fa;
   logic file_op;
   logic accept;
   logic take_two;

   function automatic logic is_port(input logic [6:0] a);
      is_port = (a == decoder_pkg::ADDR_PORT_A) ||
         (a == decoder_pkg::ADDR_PORT_B);
   endfunction

   always_comb
   begin
      pfx = insn_word[13:12];
      nib = insn_word[11:8];
      dst = insn_word[decoder_pkg::DEST_BIT];
      fa = insn_word[6:0];
      file_op = 1'b0;
      dec_next = '0;
      dec_next.alu_op = decoder_pkg::ALU_NONE;
      dec_next.literal = insn_word[7:0];
      dec_next.file_addr = fa;
      dec_next.bit_index = insn_word[9:7];
      unique case (pfx)
         decoder_pkg::PFX_BYTE:
         begin
            dec_next.reads_file = 1'b1;
            dec_next.write_acc = ~dst;
            dec_next.write_file = dst;
            file_op = 1'b1;
            unique case (nib)
               decoder_pkg::NIB_MISC:
               begin
                  dec_next.reads_file = 1'b0;
                  dec_next.write_acc = 1'b0;
                  dec_next.write_file = dst;
                  dec_next.alu_op = decoder_pkg::ALU_PASS_F;
                  file_op = dst;
                  if (!dst)
                  begin
                     dec_next.alu_op = decoder_pkg::ALU_NONE;
                     if (insn_word == decoder_pkg::W_STANDBY)
                     begin
                        dec_next.is_standby = 1'b1;
                        dec_next.upd_timeout_powerdown = 1'b1;
                     end
                     else if (insn_word == decoder_pkg::W_WDCLR)
                     begin
                        dec_next.is_wd_clear = 1'b1;
                        dec_next.upd_timeout_powerdown = 1'b1;
                     end
                     else if (insn_word == decoder_pkg::W_RETURN ||
                        insn_word == decoder_pkg::W_RETINT)
                     begin
                        dec_next.is_return = 1'b1;
                        dec_next.pc_change = 1'b1;
                     end
                     else if (insn_word[4:0] != 5'h00 ||
                        insn_word[7] != 1'b0)
                        dec_next.illegal = 1'b1;
                  end
               end
               decoder_pkg::NIB_CLR:
               begin
                  dec_next.reads_file = 1'b0;
                  dec_next.alu_op = decoder_pkg::ALU_ZERO;
                  dec_next.upd_z = 1'b1;
               end
               decoder_pkg::NIB_OR:
               begin
                  dec_next.alu_op = decoder_pkg::ALU_OR;
                  dec_next.upd_z = 1'b1;
               end
               decoder_pkg::NIB_AND:
               begin
                  dec_next.alu_op = decoder_pkg::ALU_AND;
                  dec_next.upd_z = 1'b1;
               end
               decoder_pkg::NIB_XOR:
               begin
                  dec_next.alu_op = decoder_pkg::ALU_XOR;
                  dec_next.upd_z = 1'b1;
               end
               decoder_pkg::NIB_ADD, decoder_pkg::NIB_SUB:
               begin
                  dec_next.alu_op = (nib == decoder_pkg::NIB_ADD) ?
                     decoder_pkg::ALU_ADD : decoder_pkg::ALU_SUB;
                  dec_next.upd_z = 1'b1;
                  dec_next.upd_digit_carry = 1'b1;
                  dec_next.upd_c = 1'b1;
               end
               decoder_pkg::NIB_DEC, decoder_pkg::NIB_INC:
               begin
                  dec_next.alu_op = (nib == decoder_pkg::NIB_DEC) ?
                     decoder_pkg::ALU_DEC : decoder_pkg::ALU_INC;
                  dec_next.upd_z = 1'b1;
               end
               decoder_pkg::NIB_DECSKP, decoder_pkg::NIB_INCSKP:
               begin
                  dec_next.alu_op = (nib == decoder_pkg::NIB_DECSKP) ?
                     decoder_pkg::ALU_DEC : decoder_pkg::ALU_INC;
                  dec_next.skip_on_zero = 1'b1;
               end
               decoder_pkg::NIB_MOV:
               begin
                  dec_next.alu_op = decoder_pkg::ALU_PASS_F;
                  dec_next.upd_z = 1'b1;
               end
               decoder_pkg::NIB_COM:
               begin
                  dec_next.alu_op = decoder_pkg::ALU_COM;
                  dec_next.upd_z = 1'b1;
               end
               decoder_pkg::NIB_RLC, decoder_pkg::NIB_RRC:
               begin
                  dec_next.alu_op = (nib == decoder_pkg::NIB_RLC) ?
                     decoder_pkg::ALU_RLC : decoder_pkg::ALU_RRC;
                  dec_next.upd_c = 1'b1;
               end
               decoder_pkg::NIB_SWAP:
                  dec_next.alu_op = decoder_pkg::ALU_SWAP;
            endcase
         end
         decoder_pkg::PFX_BIT:
         begin
            dec_next.reads_file = 1'b1;
            dec_next.alu_op = decoder_pkg::ALU_BIT;
            file_op = 1'b1;
            unique case (insn_word[11:10])
               decoder_pkg::BOP_CLR:
                  dec_next.write_file = 1'b1;
               decoder_pkg::BOP_SET:
               begin
                  dec_next.write_file = 1'b1;
                  dec_next.bit_value = 1'b1;
               end
               decoder_pkg::BOP_TSC:
                  dec_next.bit_test = 1'b1;
               decoder_pkg::BOP_TSS:
               begin
                  dec_next.bit_test = 1'b1;
                  dec_next.skip_if_set = 1'b1;
               end
            endcase
         end
         decoder_pkg::PFX_JUMP:
            dec_next.pc_change = 1'b1;
         decoder_pkg::PFX_LIT:
         begin
            dec_next.use_literal = 1'b1;
            dec_next.write_acc = 1'b1;
            if (nib == decoder_pkg::LIT_OR)
            begin
               dec_next.alu_op = decoder_pkg::ALU_OR;
               dec_next.upd_z = 1'b1;
            end
            else if (nib == decoder_pkg::LIT_AND)
            begin
               dec_next.alu_op = decoder_pkg::ALU_AND;
               dec_next.upd_z = 1'b1;
            end
            else if (nib == decoder_pkg::LIT_XOR)
            begin
               dec_next.alu_op = decoder_pkg::ALU_XOR;
               dec_next.upd_z = 1'b1;
            end
            else if (nib[3:1] == decoder_pkg::LIT_SUB3 ||
               nib[3:1] == decoder_pkg::LIT_ADD3)
            begin
               dec_next.alu_op = nib[1] ? decoder_pkg::ALU_ADD :
                  decoder_pkg::ALU_SUB;
               dec_next.upd_z = 1'b1;
               dec_next.upd_digit_carry = 1'b1;
               dec_next.upd_c = 1'b1;
            end
            else if (nib[3:2] == decoder_pkg::LIT_RET2)
            begin
               dec_next.alu_op = decoder_pkg::ALU_PASS_K;
               dec_next.is_return = 1'b1;
               dec_next.pc_change = 1'b1;
            end
            else if (nib[3:2] == decoder_pkg::LIT_MOV2)
               dec_next.alu_op = decoder_pkg::ALU_PASS_K;
            else
               dec_next.illegal = 1'b1;
         end
      endcase
      // All four bit ops count for the timer check, only bit clear/set count as writes for the port check
      dec_next.clr_prescaler = file_op && prescaler_on_timer &&
         (fa == decoder_pkg::ADDR_TIMER_ZERO) &&
         (pfx != decoder_pkg::PFX_BYTE || dst);
      dec_next.pins_operand = dec_next.reads_file &&
         dec_next.write_file && is_port(fa);
      dec_next.status_flag_mask = dec_next.write_file &&
         (fa == decoder_pkg::ADDR_STATUS) &&
         (dec_next.upd_z || dec_next.upd_digit_carry ||
          dec_next.upd_c);
   end

   //==========================================================
   // Issue register
   //==========================================================
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         decode_reg <= '0;
         decode_valid <= 1'b0;
      end
      else
      begin
         decode_valid <= accept;
         if (accept)
            decode_reg <= dec_next;
      end
   end

   assign decode_out = decode_reg;

   // The word fetched while a taken skip or jump decides is dropped
   assign accept = insn_valid && !busy && !flush_cycle &&
      !take_two;

   //==========================================================
   // Two-cycle sequencing
   //==========================================================
   always_comb
   begin
      // Taken skip or PC change forces a no-op second cycle
      take_two = decode_valid && (decode_reg.pc_change ||
         (decode_reg.skip_on_zero && test_result_zero) ||
         (decode_reg.bit_test &&
          (test_result_zero != decode_reg.skip_if_set)));
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         flush_cycle <= 1'b0;
         busy <= 1'b0;
      end
      else
      begin
         flush_cycle <= take_two;
         busy <= take_two;
      end
   end
endmodule
`default_nettype wire

// ===== test/datapath_model.sv
`default_nettype none
module datapath_model
(
   input wire logic clk,
   input wire decoder_pkg::decode_type decode_out,
   input wire logic decode_valid,
   input wire logic [7:0] file_value,
   output logic test_result_zero
);
   logic [7:0] res;
   logic idle_reg = 1'b0;
   // Outside a decode slot the answer wanders, so nothing can lean on it
   always_ff @(posedge clk)
   begin
      idle_reg <= !idle_reg;
   end
   always_comb
   begin
      res = file_value;
      if (decode_out.alu_op == decoder_pkg::ALU_DEC)
         res = file_value - 8'h01;
      if (decode_out.alu_op == decoder_pkg::ALU_INC)
         res = file_value + 8'h01;
      if (!decode_valid)
         test_result_zero = idle_reg;
      else if (decode_out.bit_test)
         test_result_zero = !file_value[decode_out.bit_index];
      else
         test_result_zero = (res == 8'h00);
   end
endmodule
`default_nettype wire

// ===== test/decoder_asserts.sv
`default_nettype none
module decoder_asserts
(
   input wire logic clk,
   input wire logic rst,
   input wire logic insn_valid,
   input wire logic [13:0] insn_word,
   input wire logic test_result_zero,
   input wire logic prescaler_on_timer,
   input wire decoder_pkg::decode_type decode_out,
   input wire logic decode_valid,
   input wire logic flush_cycle,
   input wire logic busy
);
   logic acc;
   logic hit;
   logic two;
   logic [2:0] fl;
   logic [13:0] w_reg;
   decoder_pkg::decode_type d;
   assign d = decode_out;
   assign fl = {d.upd_z, d.upd_digit_carry, d.upd_c};
   assign hit = d.bit_test ? d.skip_if_set ^ test_result_zero :
      test_result_zero;
   // A taken skip or jump drops the word fetched alongside it
   assign two = decode_valid &&
      (d.pc_change || ((d.skip_on_zero || d.bit_test) && hit));
   assign acc = insn_valid && !busy && !flush_cycle && !two;
   // Word that produced the current decode
   always_ff @(posedge clk)
   begin
      if (acc)
         w_reg <= insn_word;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_nop_slot;
      flush_cycle && busy && !decode_valid ##1 !flush_cycle;
   endsequence
   property p_logic_z;
      acc && insn_word[13:8] inside {6'h04, 6'h05, 6'h06} |=>
         decode_valid && fl == 3'h4;
   endproperty
   a_logic_z: assert property (p_logic_z)
      else $error("logic flags");
   property p_skip;
      decode_valid && w_reg[13:8] inside {6'h0B, 6'h0F} |->
         d.skip_on_zero && fl == 3'h0;
   endproperty
   a_skip: assert property (p_skip)
      else $error("skip decode");
   property p_rotate;
      decode_valid && w_reg[13:9] == 5'h06 |-> fl == 3'h1;
   endproperty
   a_rotate: assert property (p_rotate)
      else $error("rotate flags");
   property p_bit_test;
      decode_valid && w_reg[13:11] == 3'h3 |-> d.bit_test && fl == 3'h0 &&
         d.bit_index == w_reg[9:7] && d.file_addr == w_reg[6:0] &&
         d.skip_if_set == w_reg[10];
   endproperty
   a_bit_test: assert property (p_bit_test)
      else $error("bit fields");
   property p_no_skip;
      decode_valid && d.bit_test && !hit |=> !flush_cycle;
   endproperty
   a_no_skip: assert property (p_no_skip)
      else $error("extra cycle");
   property p_lit_logic;
      decode_valid && w_reg[13:8] inside {6'h38, 6'h39, 6'h3A} |->
         d.write_acc && fl == 3'h4 && d.literal == w_reg[7:0];
   endproperty
   a_lit_logic: assert property (p_lit_logic)
      else $error("lit logic");
   property p_lit_arith;
      decode_valid && w_reg[13:10] == 4'hF |-> d.write_acc && fl == 3'h7;
   endproperty
   a_lit_arith: assert property (p_lit_arith)
      else $error("lit arith");
   property p_ret_lit;
      decode_valid && w_reg[13:10] == 4'hD |->
         d.is_return && d.literal == w_reg[7:0] ##1 s_nop_slot;
   endproperty
   a_ret_lit: assert property (p_ret_lit)
      else $error("return lit");
   property p_ctl;
      decode_valid && w_reg inside {14'h0063, 14'h0064} |->
         d.upd_timeout_powerdown && fl == 3'h0 ##1 !flush_cycle;
   endproperty
   a_ctl: assert property (p_ctl)
      else $error("control word");
   property p_clear_file;
      decode_valid && w_reg[13:7] == 7'h03 |->
         d.write_file && fl == 3'h4 ##1 !flush_cycle;
   endproperty
   a_clear_file: assert property (p_clear_file)
      else $error("clear");
   property p_two_cycle;
      decode_valid && (d.skip_on_zero || d.bit_test) && hit |=> s_nop_slot;
   endproperty
   a_two_cycle: assert property (p_two_cycle)
      else $error("no flush");
   property p_pc_change;
      decode_valid && d.pc_change |=> s_nop_slot;
   endproperty
   a_pc_change: assert property (p_pc_change)
      else $error("pc change");
   property p_status_mask;
      decode_valid && d.write_file && d.file_addr == 7'h03 && fl != 3'h0 |->
         d.status_flag_mask;
   endproperty
   a_status_mask: assert property (p_status_mask)
      else $error("status mask");
endmodule
bind instruction_word_decoder decoder_asserts u_decoder_asserts
(
   .clk(clk), .rst(rst), .insn_valid(insn_valid), .insn_word(insn_word),
   .test_result_zero(test_result_zero),
   .prescaler_on_timer(prescaler_on_timer), .decode_out(decode_out),
   .decode_valid(decode_valid), .flush_cycle(flush_cycle), .busy(busy)
);
`default_nettype wire

// ===== test/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic insn_valid = 1'b0;
   logic [13:0] insn_word = 14'h0000;
   logic prescaler_on_timer = 1'b0;
   logic [7:0] file_value = 8'h00;
   logic test_result_zero;
   decoder_pkg::decode_type decode_out;
   logic decode_valid;
   logic flush_cycle;
   logic busy;
   int errors = 0;
   int n_tests = 0;
   integer seed = 95;
   logic [13:0] base[20] = '{14'h0400, 14'h0500, 14'h0600, 14'h0B00,
      14'h0F00, 14'h0C00, 14'h0D00, 14'h1000, 14'h1400, 14'h1800, 14'h1C00,
      14'h3800, 14'h3900, 14'h3A00, 14'h3C00, 14'h3E00, 14'h3400, 14'h0063,
      14'h0064, 14'h0180};
   logic [13:0] mask[20] = '{14'h0FF, 14'h0FF, 14'h0FF, 14'h0FF, 14'h0FF,
      14'h0FF, 14'h0FF, 14'h3FF, 14'h3FF, 14'h3FF, 14'h3FF, 14'h0FF, 14'h0FF,
      14'h0FF, 14'h1FF, 14'h1FF, 14'h3FF, 14'h000, 14'h000, 14'h07F};
   logic [2:0] flg[20] = '{3'h4, 3'h4, 3'h4, 3'h0, 3'h0, 3'h1, 3'h1, 3'h0,
      3'h0, 3'h0, 3'h0, 3'h4, 3'h4, 3'h4, 3'h7, 3'h7, 3'h0, 3'h0, 3'h0, 3'h4};
   logic [13:0] cw[6] = '{14'h0481, 14'h0481, 14'h0486, 14'h0406, 14'h0483,
      14'h0101};
   always #25 clk = ~clk;
   instruction_word_decoder u_instruction_word_decoder
   (
      .clk(clk), .rst(rst), .insn_valid(insn_valid), .insn_word(insn_word),
      .test_result_zero(test_result_zero),
      .prescaler_on_timer(prescaler_on_timer), .decode_out(decode_out),
      .decode_valid(decode_valid), .flush_cycle(flush_cycle), .busy(busy)
   );
   datapath_model u_datapath_model
   (
      .clk(clk), .decode_out(decode_out), .decode_valid(decode_valid),
      .file_value(file_value), .test_result_zero(test_result_zero)
   );
   // ==========
   // Expectations and checks
   function automatic logic exp_flush(logic [13:0] w, logic [7:0] f);
      logic [7:0] r;
      r = w[10] ? f + 8'h01 : f - 8'h01;
      if (w[13:11] == 3'h3)
         return f[w[9:7]] == w[10];
      if (w[13:8] == 6'h0B || w[13:8] == 6'h0F)
         return r == 8'h00;
      return w[13:10] == 4'hD;
   endfunction
   task automatic check(string name, logic [15:0] exp, logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic test_done();
      if (errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic run(logic [13:0] w, logic [7:0] f, logic p);
      @(negedge clk);
      insn_valid = 1'b1;
      insn_word = w;
      file_value = f;
      prescaler_on_timer = p;
      @(negedge clk);
      insn_valid = 1'b0;
      insn_word = ~w;
      check("decode_valid", 16'h1, {15'h0, decode_valid});
      @(negedge clk);
      check("flush", {15'h0, exp_flush(w, f)},
         {15'h0, flush_cycle});
      check("busy", {15'h0, exp_flush(w, f)}, {15'h0, busy});
      @(negedge clk);
   endtask
   // ==========
   // Main sequence
   initial
   begin
      int i;
      logic [7:0] f;
      logic [13:0] w;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      for (int k = 0; k < 200; k++)
      begin
         i = k % 20;
         f = k < 20 ? 8'h01 : k < 40 ? 8'hFF : 8'($random(seed));
         w = base[i] | (14'($random(seed)) & mask[i]);
         run(w, f, 1'($random(seed)));
         check("flags", {13'h0, flg[i]}, {13'h0, decode_out.upd_z,
            decode_out.upd_digit_carry, decode_out.upd_c});
         if (i < 7)
            check("dest", {14'h0, w[7], !w[7]}, {14'h0,
               decode_out.write_file, decode_out.write_acc});
         if (i > 10 && i < 17)
            check("literal", {8'h0, w[7:0]},
               {8'h0, decode_out.literal});
         if (i == 17 || i == 18)
            check("timeout_powerdown", {13'h0, 1'b1, i == 17, i == 18},
               {13'h0, decode_out.upd_timeout_powerdown,
               decode_out.is_standby, decode_out.is_wd_clear});
         if (i == 19)
            check("clear", 16'h1,
               {15'h0, decode_out.write_file});
      end
      // Last word clears the accumulator only, so no prescaler clear
      for (int k = 0; k < 6; k++)
      begin
         run(cw[k], 8'h10, k == 0 || k == 5);
         check("side_effect", {15'h0, !k[0]}, {15'h0, k < 2 || k == 5 ?
            decode_out.clr_prescaler : k < 4 ? decode_out.pins_operand :
            decode_out.status_flag_mask});
      end
      @(negedge clk);
      insn_valid = 1'b1;
      insn_word = 14'h3811;
      @(negedge clk);
      insn_word = 14'h3922;
      check("first", 16'h0011, {8'h0, decode_out.literal});
      @(negedge clk);
      insn_valid = 1'b0;
      check("second", 16'h0122,
         {7'h0, decode_valid, decode_out.literal});
      // A jump drops the word fetched with it and refuses the next offer
      @(negedge clk);
      insn_valid = 1'b1;
      insn_word = 14'h2805;
      @(negedge clk);
      insn_word = 14'h3833;
      @(negedge clk);
      check("jump_nop", 16'h0001,
         {14'h0, decode_valid, flush_cycle});
      @(negedge clk);
      check("jump_busy", 16'h0000,
         {14'h0, decode_valid, flush_cycle});
      @(negedge clk);
      insn_valid = 1'b0;
      check("after_jump", 16'h0133,
         {7'h0, decode_valid, decode_out.literal});
      repeat (2) @(negedge clk);
      test_done();
   end
   initial
   begin
      #1000000;
      errors++;
      test_done();
   end
endmodule
`default_nettype wire
